/* epic_defines.svh */
// constants for the external pin interrupt controller
// assumes every file that needs a figure includes this by bare name
`ifndef EPIC_DEFINES_SVH
`define EPIC_DEFINES_SVH

// structure sizes
`define EPIC_NPIN    8
`define EPIC_NCH     8
`define EPIC_PINW    3
`define EPIC_CHW     3
`define EPIC_SENSEW  3
// pins, nmi line, soft reset bit, enable bit
`define EPIC_SYNC_W  11
`define EPIC_SYNC_NMI    8
`define EPIC_SYNC_SWRST  9
`define EPIC_SYNC_EN     10

// sense setting codes
`define EPIC_SENSE_NONE  3'h0
`define EPIC_SENSE_RISE  3'h1
`define EPIC_SENSE_FALL  3'h2
`define EPIC_SENSE_BOTH  3'h3
`define EPIC_SENSE_HIGH  3'h4
`define EPIC_SENSE_LOW   3'h5

`endif

/* epic_pkg.sv */
// types shared by the controller core and its input synchroniser
// assumes epic_defines.svh is on the include path
package epic_pkg;
  `include "epic_defines.svh"

  // sense setting of one channel or of the nmi line
  typedef enum logic [`EPIC_SENSEW-1:0] {
    SENSE_NONE = `EPIC_SENSE_NONE,
    SENSE_RISE = `EPIC_SENSE_RISE,
    SENSE_FALL = `EPIC_SENSE_FALL,
    SENSE_BOTH = `EPIC_SENSE_BOTH,
    SENSE_HIGH = `EPIC_SENSE_HIGH,
    SENSE_LOW  = `EPIC_SENSE_LOW
  } epic_sense_e;

  // two-stage synchroniser state
  typedef struct packed {
    logic [`EPIC_SYNC_W-1:0] stage1;
    logic [`EPIC_SYNC_W-1:0] stage2;
  } epic_sync_s;

  // whole state of the controller core
  typedef struct packed {
    logic [`EPIC_NPIN-1:0]                 pinPrev;
    logic                                  nmiPrev;
    logic [`EPIC_NCH-1:0]                  ownValid;
    logic [`EPIC_NCH-1:0][`EPIC_PINW-1:0]  ownPin;
    logic [`EPIC_NCH-1:0]                  irqEn;
    logic [`EPIC_NCH-1:0]                  flags;
    logic                                  nmi_flag_reg;
    logic                                  irqReq;
    logic                                  nmiReq;
    logic [`EPIC_NCH-1:0]                  evtOut;
    logic                                  wake;
    logic                                  enApplied;
    logic                                  swrstApplied;
    logic                                  busy;
  } epic_state_s;
endpackage : epic_pkg

/* epic_sync.sv */
// two flip-flop synchroniser for every input that arrives from outside
// assumes its inputs are asynchronous to clk_sys and only levels
`include "epic_defines.svh"

module epic_sync
  import epic_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  // raw and synchronised levels
  input  wire logic [`EPIC_SYNC_W-1:0] dIn,
  output logic      [`EPIC_SYNC_W-1:0] qOut
);
  epic_sync_s s_reg;
  epic_sync_s s_next;

  // stage1 is read only by stage2, never by logic
  always_comb begin
    s_next        = s_reg;
    s_next.stage1 = dIn;
    s_next.stage2 = s_reg.stage1;
  end

  // register the whole state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign qOut = s_reg.stage2;
endmodule : epic_sync

/* epic_core.sv */
// external pin interrupt controller: pin sensing, flags, requests,
// output events and sleep wake-up
// assumes control ports other than pins and the soft reset / enable
// bits are driven by logic on clk_sys; pins and those bits are async
//
// Function
// R1 - request rises when a flag and its enable are both set
// R2 - request holds until flag cleared, enable dropped or reset
// R3 - one shared request for all channels, separate nmi request
// R4 - channel mapped on several pins: only the first mapped pin counts
// R5 - event output per channel only while its event enable is set
// R6 - sense match on a pin emits that channel's event if enabled
// R7 - in sleep a match on an interrupt-enabled channel signals wake-up
// R8 - soft reset and enable bits pass a synchroniser before acting
// R9 - busy output shows a synchronised control write not yet applied; the code raises busy with the apply, for one cycle
`include "epic_defines.svh"

module epic_core
  import epic_pkg::*;
(
  // clock and reset
  input  wire logic                                   clk_sys,
  input  wire logic                                   rst_n,
  // asynchronous inputs
  input  wire logic [`EPIC_NPIN-1:0]                  extLine,
  input  wire logic                                   nmiLine,
  input  wire logic                                   softResetBit,
  input  wire logic                                   enableBit,
  // channel configuration
  input  wire logic [`EPIC_NCH-1:0][`EPIC_SENSEW-1:0] senseConfig,
  input  wire logic [`EPIC_SENSEW-1:0]                nmiSense,
  input  wire logic [`EPIC_NPIN-1:0]                  pinMapEn,
  input  wire logic [`EPIC_NPIN-1:0][`EPIC_CHW-1:0]   pinMapCh,
  input  wire logic [`EPIC_NCH-1:0]                   eventOutputEn,
  // enable and flag control pulses, sleep mode level
  input  wire logic [`EPIC_NCH-1:0]                   irqEnableSet,
  input  wire logic [`EPIC_NCH-1:0]                   irqEnableClr,
  input  wire logic [`EPIC_NCH-1:0]                   flagClear,
  input  wire logic                                   nmiClear,
  input  wire logic                                   sleepMode,
  // requests and events
  output logic                                        irqReq,
  output logic                                        nmiReq,
  output logic      [`EPIC_NCH-1:0]                   extEvent,
  output logic                                        wakeReq,
  // status
  output logic      [`EPIC_NCH-1:0]                   irqFlags,
  output logic                                        nmi_flag_reg,
  output logic      [`EPIC_NCH-1:0]                   irqEnable,
  output logic                                        ctrlEnabled,
  output logic                                        syncBusy
);
  epic_state_s s_reg;
  epic_state_s s_next;

  logic [`EPIC_SYNC_W-1:0] syncQ;
  logic [`EPIC_NPIN-1:0]   pinNow;
  logic                    nmiNow;
  logic                    swrstSync;
  logic                    enSync;
  logic [`EPIC_NCH-1:0]    chMatch;
  logic                    nmiMatch;

  // R8 synchronise control bits
  epic_sync u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .dIn     ({enableBit, softResetBit, nmiLine, extLine}),
    .qOut    (syncQ)
  );

  assign pinNow    = syncQ[`EPIC_NPIN-1:0];
  assign nmiNow    = syncQ[`EPIC_SYNC_NMI];
  assign swrstSync = syncQ[`EPIC_SYNC_SWRST];
  assign enSync    = syncQ[`EPIC_SYNC_EN];

  // compare one line against its sense setting; unknown codes never fire
  function automatic logic senseMatch(
    input logic [`EPIC_SENSEW-1:0] cfg,
    input logic                    cur,
    input logic                    prev
  );
    logic hit;
    hit = 1'b0;
    case (cfg)
      `EPIC_SENSE_RISE: hit = cur & ~prev;
      `EPIC_SENSE_FALL: hit = ~cur & prev;
      `EPIC_SENSE_BOTH: hit = cur ^ prev;
      `EPIC_SENSE_HIGH: hit = cur;
      `EPIC_SENSE_LOW:  hit = ~cur;
      default:          hit = 1'b0;
    endcase
    return hit;
  endfunction : senseMatch

  // per channel match, seen through the owning pin only
  for (genvar gc = 0; gc < `EPIC_NCH; gc++) begin : g_ch
    // R6 sense match on owner
    assign chMatch[gc] = s_reg.enApplied & s_reg.ownValid[gc] &
                         senseMatch(senseConfig[gc],
                                    pinNow[s_reg.ownPin[gc]],
                                    s_reg.pinPrev[s_reg.ownPin[gc]]);
  end

  // the nmi line has no mask and its own sense setting
  assign nmiMatch = s_reg.enApplied &
                    senseMatch(nmiSense, nmiNow, s_reg.nmiPrev);

  // next state of the whole controller
  always_comb begin
    s_next         = s_reg;
    s_next.pinPrev = pinNow;
    s_next.nmiPrev = nmiNow;

    // R4 release an owner that was unmapped or moved to another channel
    for (int c = 0; c < `EPIC_NCH; c++) begin
      if (s_reg.ownValid[c] &&
          (!pinMapEn[s_reg.ownPin[c]] ||
           pinMapCh[s_reg.ownPin[c]] != `EPIC_CHW'(c))) begin
        s_next.ownValid[c] = 1'b0;
      end
      // R4 free channel taken by lowest mapped pin
      if (!s_next.ownValid[c]) begin
        for (int p = `EPIC_NPIN - 1; p >= 0; p--) begin
          if (pinMapEn[p] && pinMapCh[p] == `EPIC_CHW'(c)) begin
            s_next.ownValid[c] = 1'b1;
            s_next.ownPin[c]   = `EPIC_PINW'(p);
          end
        end
      end
    end

    // enables: a set in the same cycle as a clear wins
    s_next.irqEn = (s_reg.irqEn & ~irqEnableClr) | irqEnableSet;

    // flags: a new match wins over a clear in the same cycle
    s_next.flags   = (s_reg.flags & ~flagClear) | chMatch;
    s_next.nmi_flag_reg = (s_reg.nmi_flag_reg & ~nmiClear) | nmiMatch;

    // R5 events gated by their enable
    s_next.evtOut = chMatch & eventOutputEn;

    // R7 wake-up while asleep
    s_next.wake = sleepMode & |(chMatch & s_reg.irqEn);

    // R8 apply synchronised bits; soft reset forces disable
    s_next.swrstApplied = swrstSync;
    s_next.enApplied    = enSync & ~swrstSync;

    // R9 busy for one cycle, raised on the same edge that applies a synchronised change
    s_next.busy = (swrstSync != s_reg.swrstApplied) |
                  ((enSync & ~swrstSync) != s_reg.enApplied);

    // R8 soft reset clears all control state on its rising edge
    if (swrstSync && !s_reg.swrstApplied) begin
      s_next.ownValid = '0;
      s_next.irqEn    = '0;
      s_next.flags    = '0;
      s_next.nmi_flag_reg  = 1'b0;
      s_next.evtOut   = '0;
      s_next.wake     = 1'b0;
    end

    // R1 R2 request follows flag and enable from their next values
    // R3 shared line for channels
    s_next.irqReq = |(s_next.flags & s_next.irqEn);
    // R3 dedicated nmi line
    s_next.nmiReq = s_next.nmi_flag_reg;
  end

  // register the whole state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // every output straight from the state register
  assign irqReq      = s_reg.irqReq;
  assign nmiReq      = s_reg.nmiReq;
  assign extEvent    = s_reg.evtOut;
  assign wakeReq     = s_reg.wake;
  assign irqFlags    = s_reg.flags;
  assign nmi_flag_reg     = s_reg.nmi_flag_reg;
  assign irqEnable   = s_reg.irqEn;
  assign ctrlEnabled = s_reg.enApplied;
  assign syncBusy    = s_reg.busy;
endmodule : epic_core

/* epic_core_checker.sv */
// port checker for the pin interrupt controller core
// assumes one clock domain and a bind onto epic_core
`include "epic_defines.svh"
module epic_core_checker
  import epic_pkg::*;
(
  // clock and reset
  input wire logic                clk_sys,
  input wire logic                rst_n,
  // inputs watched
  input wire logic                enableBit,
  input wire logic                softResetBit,
  input wire logic                sleepMode,
  input wire logic [`EPIC_NCH-1:0] eventOutputEn,
  input wire logic [`EPIC_NCH-1:0] irqEnableClr,
  input wire logic [`EPIC_NCH-1:0] flagClear,
  // outputs watched
  input wire logic                irqReq,
  input wire logic                nmiReq,
  input wire logic                nmi_flag_reg,
  input wire logic                wakeReq,
  input wire logic                ctrlEnabled,
  input wire logic                syncBusy,
  input wire logic [`EPIC_NCH-1:0] extEvent,
  input wire logic [`EPIC_NCH-1:0] irqFlags,
  input wire logic [`EPIC_NCH-1:0] irqEnable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // shared request follows flags and enables
  irq_or_a: assert property (irqReq == |(irqFlags & irqEnable))
    else $error("shared request mismatch");
  nmi_line_a: assert property (nmiReq == nmi_flag_reg)
    else $error("nmi request mismatch");
  irq_hold_a: assert property ($fell(irqReq) |->
    $past(flagClear) != '0 || $past(irqEnableClr) != '0 || syncBusy)
    else $error("request dropped without cause");
  evt_gate_a: assert property ($stable(eventOutputEn) |->
    !(|(extEvent & ~eventOutputEn))) else $error("event not gated");
  off_quiet_a: assert property (!ctrlEnabled [*2] |->
    extEvent == '0 && !wakeReq) else $error("match while disabled");
  wake_sleep_a: assert property (wakeReq |->
    $past(sleepMode) && $past(irqEnable) != '0)
    else $error("wake outside sleep");
  en_sync_a: assert property ($rose(enableBit) && !ctrlEnabled &&
    !softResetBit |-> ##2 !ctrlEnabled ##1 ctrlEnabled)
    else $error("enable not synchronised");
  busy_change_a: assert property ($changed(ctrlEnabled) |-> syncBusy)
    else $error("no busy on change");
  busy_pulse_a: assert property ($rose(syncBusy) |=> !syncBusy)
    else $error("busy longer than one cycle");
endmodule : epic_core_checker

/* epic_isr_model.sv */
// partner: interrupt taker that clears the flags it sees
// assumes pulses change just after the rising edge, like the bench
`include "epic_defines.svh"
module epic_isr_model
  import epic_pkg::*;
(
  // clock and handler switch
  input  wire logic                clk_sys,
  input  wire logic                ackOn,
  // request and flags seen
  input  wire logic                irqReq,
  input  wire logic [`EPIC_NCH-1:0] irqFlags,
  // write-1-clear pulse
  output logic      [`EPIC_NCH-1:0] flagClear = '0
);
  timeunit 1ns;
  timeprecision 1ns;
  int                   waitCnt = 0;
  logic [`EPIC_NCH-1:0] clrNext = '0;
  // handler clears flags
  // decide on the values standing at the edge, drive just after it;
  // two-cycle entry delay, so a clear never lands on the raising edge
  always @(posedge clk_sys) begin
    clrNext = '0;
    if (irqReq && ackOn && waitCnt == 1) begin
      clrNext = irqFlags;
      waitCnt = 0;
    end else begin
      waitCnt = (irqReq && ackOn) ? waitCnt + 1 : 0;
    end
    #5;
    flagClear = clrNext;
  end
endmodule : epic_isr_model

/* test_external_pin_interrupt_ctrl.sv */
// bench for the pin interrupt controller core
// assumes core, checker and partner model are compiled first
`include "epic_defines.svh"
module test_external_pin_interrupt_ctrl
  import epic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst_n, nmiLine, softResetBit, enableBit, nmiClear;
  logic sleepMode, ackOn, irqReq, nmiReq, wakeReq, nmi_flag_reg;
  logic ctrlEnabled, syncBusy;
  logic [7:0] extLine, pinMapEn, eventOutputEn, irqEnableSet;
  logic [7:0] irqEnableClr, flagClear, extEvent, irqFlags, irqEnable;
  logic [7:0][2:0] senseConfig, pinMapCh;
  logic [2:0] nmiSense;
  int fails = 0, checks = 0, cyc = 0;
  epic_core epic_core_i (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .extLine       (extLine),
    .nmiLine       (nmiLine),
    .softResetBit  (softResetBit),
    .enableBit     (enableBit),
    .senseConfig   (senseConfig),
    .nmiSense      (nmiSense),
    .pinMapEn      (pinMapEn),
    .pinMapCh      (pinMapCh),
    .eventOutputEn (eventOutputEn),
    .irqEnableSet  (irqEnableSet),
    .irqEnableClr  (irqEnableClr),
    .flagClear     (flagClear),
    .nmiClear      (nmiClear),
    .sleepMode     (sleepMode),
    .irqReq        (irqReq),
    .nmiReq        (nmiReq),
    .extEvent      (extEvent),
    .wakeReq       (wakeReq),
    .irqFlags      (irqFlags),
    .nmi_flag_reg       (nmi_flag_reg),
    .irqEnable     (irqEnable),
    .ctrlEnabled   (ctrlEnabled),
    .syncBusy      (syncBusy)
  );
  epic_isr_model epic_isr_model_i (
    .clk_sys   (clk_sys),
    .ackOn     (ackOn),
    .irqReq    (irqReq),
    .irqFlags  (irqFlags),
    .flagClear (flagClear)
  );
  // 20 MHz clock
  initial begin
    clk_sys = 0;
    forever #25 clk_sys = ~clk_sys;
  end
  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask : step
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // hang guard, well above the run's fewer than 80 cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    {rst_n, nmiLine, softResetBit, enableBit, nmiClear, sleepMode} = '0;
    {ackOn, extLine, pinMapEn, eventOutputEn, irqEnableSet} = '0;
    {irqEnableClr, senseConfig, pinMapCh, nmiSense} = '0;
    step(3);
    rst_n = 1;
    step(1);
    chk({irqReq, nmiReq, wakeReq, ctrlEnabled}, 8'h00);
    chk(irqFlags | irqEnable | extEvent, 8'h00);
    enableBit = 1;
    step(2);
    chk(ctrlEnabled, 8'h00);
    step(1);
    chk({ctrlEnabled, syncBusy}, 8'h03);
    // pin1 claims ch0 first, pin0 mapped to ch0 later
    pinMapCh[2] = 3'h2;
    pinMapEn = 8'h06;
    senseConfig[0] = SENSE_RISE;
    senseConfig[2] = SENSE_HIGH;
    eventOutputEn = 8'h01;
    irqEnableSet = 8'h01;
    step(1);
    chk(syncBusy, 8'h00);
    irqEnableSet = 8'h00;
    pinMapEn = 8'h07;
    step(2);
    extLine = 8'h01;
    step(4);
    chk(irqFlags, 8'h00);
    extLine = 8'h03;
    step(3);
    chk({irqReq, irqFlags[0], extEvent[0]}, 8'h07);
    step(1);
    chk(irqReq, 8'h01);
    chk(extEvent, 8'h00);
    irqEnableClr = 8'h01;
    step(1);
    irqEnableClr = 8'h00;
    step(1);
    chk(irqReq, 8'h00);
    chk(irqFlags, 8'h01);
    irqEnableSet = 8'h01;
    ackOn = 1;
    step(1);
    irqEnableSet = 8'h00;
    for (int i = 0; i < 20 && irqReq !== 1'b0; i++) step(1);
    chk(irqFlags, 8'h00);
    extLine = 8'h07;
    step(4);
    chk({irqReq, irqFlags[2]}, 8'h01);
    chk(extEvent, 8'h00);
    sleepMode = 1;
    irqEnableSet = 8'h04;
    step(1);
    irqEnableSet = 8'h00;
    step(3);
    chk(wakeReq, 8'h01);
    sleepMode = 0;
    ackOn = 0;
    step(3);
    chk(wakeReq, 8'h00);
    nmiSense = SENSE_RISE;
    nmiLine = 1;
    step(4);
    chk({nmiReq, nmi_flag_reg}, 8'h03);
    nmiClear = 1;
    step(1);
    nmiClear = 0;
    step(1);
    chk(nmiReq, 8'h00);
    // ch0 through its owner pin1: fall, both edges, low level, none
    senseConfig[0] = SENSE_FALL;
    extLine = 8'h05;
    step(3);
    chk(extEvent, 8'h01);
    chk(irqFlags, 8'h05);
    senseConfig[0] = SENSE_BOTH;
    extLine = 8'h07;
    step(3);
    chk(extEvent, 8'h01);
    senseConfig[0] = SENSE_LOW;
    extLine = 8'h05;
    step(4);
    chk(extEvent, 8'h01);
    senseConfig[0] = SENSE_NONE;
    step(1);
    chk(extEvent, 8'h00);
    softResetBit = 1;
    step(3);
    chk({ctrlEnabled, syncBusy}, 8'h01);
    chk(irqEnable, 8'h00);
    step(1);
    chk(syncBusy, 8'h00);
    wrap_up();
  end
endmodule : test_external_pin_interrupt_ctrl
bind epic_core epic_core_checker epic_core_checker_i (
  .clk_sys       (clk_sys),
  .rst_n         (rst_n),
  .enableBit     (enableBit),
  .softResetBit  (softResetBit),
  .sleepMode     (sleepMode),
  .eventOutputEn (eventOutputEn),
  .irqEnableClr  (irqEnableClr),
  .flagClear     (flagClear),
  .irqReq        (irqReq),
  .nmiReq        (nmiReq),
  .nmi_flag_reg       (nmi_flag_reg),
  .wakeReq       (wakeReq),
  .ctrlEnabled   (ctrlEnabled),
  .syncBusy      (syncBusy),
  .extEvent      (extEvent),
  .irqFlags      (irqFlags),
  .irqEnable     (irqEnable)
);
